// >>> wbnrr_pkg.sv
// Behaviour
// RULE_01 - Both machines idle until transfer start; sequencer then enters read check state.
// RULE_02 - Read check: continue only on a read with relocation negated, else idle.
// RULE_03 - Chip-select check one clock later: rom_select asserted enters first fetch state.
// RULE_04 - Address-only rom_select may be checked with read check, saving one state.
// RULE_05 - Entering first fetch state asserts registered access_go to the delay machine.
// RULE_06 - Sequencer state gives the two low memory address lines, one word each.
// RULE_07 - Delay machine leaves idle after access_go, asserting registered latch_open while counting.
// RULE_08 - latch_open raises the selected latch gate, held until delay reaches state ten.
// RULE_09 - At final delay state latch_open drops, closing the gate and capturing the word.
// RULE_10 - Each gate stays open long enough to cover the memory access time.
// RULE_11 - word_done in final delay state; sequencer advances, delay machine returns idle.
// RULE_12 - access_go stays asserted in later fetch states so counting restarts at once.
// RULE_13 - Each of the four words lands in its own latch pair, forming 64 bits.
// RULE_14 - After the fourth access starts access_go negates, preventing a fifth access.
// RULE_15 - During the fourth access only, registered pre_early_ack marks imminent completion.
// RULE_16 - Outside logic raises early_ack one clock later and transfer_ack one after.
// RULE_17 - After word_done of the fourth word the sequencer enters its decision state.
// RULE_18 - Processor negates data_bus_busy after acknowledge; latches then stop driving.
// RULE_19 - Decision state returns idle when transfer start and data_bus_busy are negated.
// RULE_20 - Decision state with transfer start asserted goes to the read check state.
// RULE_21 - Decision state with busy still asserted fetches the next burst word.
// RULE_22 - A complete 64-bit read takes 48 processor clock cycles.
// RULE_23 - Both machines return idle whenever data_bus_busy negates during a transfer.
// RULE_24 - Chip-select check returns idle when rom_select is not asserted.
// RULE_25 - pre_early_ack rises on delay seven-to-eight step, only in last fetch state.
// RULE_26 - Latches drive the 64-bit word on the data bus only while rom_select asserted.
package wbnrr_pkg;

  // ------------------------------------------------------------------
  // Widths and timing
  // ------------------------------------------------------------------
  localparam int unsigned ROM_WIDTH        = 16;
  localparam int unsigned CPU_WIDTH        = 64;
  localparam int unsigned WORD_COUNT       = 4;
  localparam int unsigned CLOCK_PERIOD_NS  = 40;
  localparam int unsigned ROM_ACCESS_NS    = 170;
  localparam int unsigned ROM_ACCESS_CYCLES =
    (ROM_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned TRANSFER_CYCLES  = 48;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [ROM_WIDTH-1:0] WORD_RESET = 16'h0000;

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_CHK_RW, SEQ_CHK_CS, SEQ_FETCH0, SEQ_FETCH1, SEQ_FETCH2, SEQ_FETCH3, SEQ_DECIDE
  } wbnrr_seq_t;

  typedef enum logic [3:0] {
    DLY_S0, DLY_S1, DLY_S2, DLY_S3, DLY_S4, DLY_S5, DLY_S6, DLY_S7, DLY_S8, DLY_S9, DLY_S10
  } wbnrr_dly_t;

endpackage

// >>> wbnrr_top.sv
`timescale 1ns/1ps
`default_nettype none
module wbnrr_top (
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  input  wire logic                            transfer_start_n,
  input  wire logic                            data_bus_busy_n,
  input  wire logic                            read_not_write,
  input  wire logic                            relocation_select,
  input  wire logic                            rom_select_n,
  input  wire logic [wbnrr_pkg::ROM_WIDTH-1:0] rom_data,
  output logic      [1:0]                      rom_addr_lo,
  output logic                                 latch_gate_a,
  output logic                                 latch_gate_b,
  output logic                                 latch_gate_c,
  output logic                                 latch_gate_d,
  output logic                                 pre_early_ack,
  output logic      [wbnrr_pkg::CPU_WIDTH-1:0] cpu_data_out,
  output logic                                 cpu_data_oe
);
  import wbnrr_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  wbnrr_seq_t             seq_reg;
  wbnrr_seq_t             seq_next;
  wbnrr_dly_t             dly_reg;
  wbnrr_dly_t             dly_next;
  logic                   access_go_reg;
  logic                   access_go_next;
  logic                   latch_open_reg;
  logic                   latch_open_next;
  logic                   word_done_reg;
  logic                   word_done_next;
  logic                   pre_ack_reg;
  logic                   pre_ack_next;
  logic [3:0]             gate;
  logic [ROM_WIDTH-1:0]   word_reg  [WORD_COUNT];
  logic [ROM_WIDTH-1:0]   word_next [WORD_COUNT];

  // Word address carried by each fetch state; other states park at zero.
  function automatic logic [1:0] seq_word_addr(input wbnrr_seq_t s);
    logic [1:0] a;
    a = 2'h0;
    unique case (s)
      SEQ_FETCH1: a = 2'h1;
      SEQ_FETCH2: a = 2'h2;
      SEQ_FETCH3: a = 2'h3;
      SEQ_IDLE, SEQ_CHK_RW, SEQ_CHK_CS, SEQ_FETCH0, SEQ_DECIDE: a = 2'h0;
    endcase
    return a;
  endfunction

  // True in any of the four word-fetch states.
  function automatic logic seq_is_fetch(input wbnrr_seq_t s);
    return (s == SEQ_FETCH0) || (s == SEQ_FETCH1) || (s == SEQ_FETCH2) || (s == SEQ_FETCH3);
  endfunction

  // ------------------------------------------------------------------
  // Sequencer machine
  // ------------------------------------------------------------------
  // Next state and the registered access_go request.
  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      SEQ_IDLE: begin
        if (!transfer_start_n) begin
          seq_next = SEQ_CHK_RW;                                   // [RULE_01]
        end
      end
      SEQ_CHK_RW: begin
        if (!relocation_select && read_not_write) begin
          seq_next = SEQ_CHK_CS;                                   // [RULE_02]
        end else begin
          seq_next = SEQ_IDLE;
        end
      end
      SEQ_CHK_CS: begin
        if (!rom_select_n) begin
          seq_next = SEQ_FETCH0;                                   // [RULE_03]
        end else begin
          seq_next = SEQ_IDLE;                                     // [RULE_24]
        end
      end
      SEQ_FETCH0, SEQ_FETCH1, SEQ_FETCH2, SEQ_FETCH3: begin
        if (data_bus_busy_n) begin
          seq_next = SEQ_IDLE;                                     // [RULE_23]
        end else if (word_done_reg) begin
          unique case (seq_reg)
            SEQ_FETCH0: seq_next = SEQ_FETCH1;                     // [RULE_11]
            SEQ_FETCH1: seq_next = SEQ_FETCH2;
            SEQ_FETCH2: seq_next = SEQ_FETCH3;
            SEQ_FETCH3: seq_next = SEQ_DECIDE;                     // [RULE_17]
            default:    seq_next = SEQ_IDLE;
          endcase
        end
      end
      SEQ_DECIDE: begin
        if (!transfer_start_n) begin
          seq_next = SEQ_CHK_RW;                                   // [RULE_20]
        end else if (data_bus_busy_n) begin
          seq_next = SEQ_IDLE;                                     // [RULE_19]
        end else begin
          seq_next = SEQ_CHK_CS;                                   // [RULE_21]
        end
      end
    endcase
    // Request a count in every fetch state, but only on the first cycle of the last one.
    access_go_next = !rom_select_n &&
                     (((seq_next == SEQ_FETCH0) || (seq_next == SEQ_FETCH1) || (seq_next == SEQ_FETCH2)) ||
                      ((seq_next == SEQ_FETCH3) && (seq_reg != SEQ_FETCH3)));  // [RULE_05] [RULE_12] [RULE_14]
  end

  // Sequencer registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg       <= SEQ_IDLE;
      access_go_reg <= 1'b0;
    end else begin
      seq_reg       <= seq_next;
      access_go_reg <= access_go_next;
    end
  end

  // ------------------------------------------------------------------
  // Delay machine
  // ------------------------------------------------------------------
  // Eleven-state counter that times one memory access.
  always_comb begin
    dly_next = dly_reg;
    if (data_bus_busy_n) begin
      dly_next = DLY_S0;                                           // [RULE_23] Also blocks a restart from S0.
    end else begin
      unique case (dly_reg)
        DLY_S0:  dly_next = access_go_reg ? DLY_S1 : DLY_S0;       // [RULE_07] [RULE_12]
        DLY_S1:  dly_next = DLY_S2;
        DLY_S2:  dly_next = DLY_S3;
        DLY_S3:  dly_next = DLY_S4;
        DLY_S4:  dly_next = DLY_S5;
        DLY_S5:  dly_next = DLY_S6;
        DLY_S6:  dly_next = DLY_S7;
        DLY_S7:  dly_next = DLY_S8;
        DLY_S8:  dly_next = DLY_S9;
        DLY_S9:  dly_next = DLY_S10;
        DLY_S10: dly_next = DLY_S0;                                // [RULE_11]
        default: dly_next = DLY_S0;
      endcase
    end
    // The gate is open from S1 up to S9 and shuts on reaching S10.
    latch_open_next = (dly_next != DLY_S0) && (dly_next != DLY_S10);  // [RULE_07] [RULE_09] [RULE_10]
    word_done_next  = (dly_next == DLY_S10);                       // [RULE_11]
    pre_ack_next    = (dly_next == DLY_S8) && (dly_reg == DLY_S7) &&
                      (seq_reg == SEQ_FETCH3);                     // [RULE_15] [RULE_25]
  end

  // Delay machine registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dly_reg        <= DLY_S0;
      latch_open_reg <= 1'b0;
      word_done_reg  <= 1'b0;
      pre_ack_reg    <= 1'b0;
    end else begin
      dly_reg        <= dly_next;
      latch_open_reg <= latch_open_next;
      word_done_reg  <= word_done_next;
      pre_ack_reg    <= pre_ack_next;
    end
  end

  // ------------------------------------------------------------------
  // Latch pairs
  // ------------------------------------------------------------------
  // Gate of the pair that the current word address selects.
  always_comb begin
    gate = 4'h0;
    if (latch_open_reg && seq_is_fetch(seq_reg)) begin
      gate[seq_word_addr(seq_reg)] = 1'b1;                         // [RULE_08]
    end
  end

  // A pair follows the memory while its gate is high and keeps the last word when it shuts.
  always_comb begin
    for (int i = 0; i < WORD_COUNT; i++) begin
      word_next[i] = gate[i] ? rom_data : word_reg[i];             // [RULE_09] [RULE_13]
    end
  end

  // Latch pair storage.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORD_COUNT; i++) begin
        word_reg[i] <= WORD_RESET;
      end
    end else begin
      for (int i = 0; i < WORD_COUNT; i++) begin
        word_reg[i] <= word_next[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Address bits come straight from the sequencer state.
  assign rom_addr_lo   = seq_word_addr(seq_reg);                   // [RULE_06]
  assign latch_gate_a  = gate[0];
  assign latch_gate_b  = gate[1];
  assign latch_gate_c  = gate[2];
  assign latch_gate_d  = gate[3];
  assign pre_early_ack = pre_ack_reg;
  // First word fetched forms the most significant quarter.
  assign cpu_data_out  = {word_reg[0], word_reg[1], word_reg[2], word_reg[3]};  // [RULE_13]
  // The bus is driven only while the memory stays selected.
  assign cpu_data_oe   = !rom_select_n;                            // [RULE_18] [RULE_26]

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Helper: cycles the gate of the current word has been open.
  logic [3:0] open_cnt_reg;
  logic [3:0] open_cnt_next;

  // Counts while the gate is open and clears once it shuts.
  always_comb begin
    open_cnt_next = latch_open_reg ? open_cnt_reg + 4'h1 : 4'h0;
  end

  // Helper counter register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      open_cnt_reg <= 4'h0;
    end else begin
      open_cnt_reg <= open_cnt_next;
    end
  end

  sequence s_fetch_start;
    (seq_reg == SEQ_CHK_CS) && !rom_select_n;
  endsequence

  sequence s_count_run;
    (dly_reg == DLY_S1) ##1 (latch_open_reg [*8]) ##1 (dly_reg == DLY_S10);
  endsequence

  property p_idle_wait;
    @(posedge clock) disable iff (!rst_n)
      (seq_reg == SEQ_IDLE) && transfer_start_n |=> (seq_reg == SEQ_IDLE) && (dly_reg == DLY_S0);
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("sequencer left idle without transfer start");  // [RULE_01]

  property p_rw_check;
    @(posedge clock) disable iff (!rst_n)
      (seq_reg == SEQ_CHK_RW) |=> (seq_reg == (($past(read_not_write) && !$past(relocation_select)) ?
                                                SEQ_CHK_CS : SEQ_IDLE));
  endproperty
  a_rw_check: assert property (p_rw_check) else $error("read check took the wrong branch");  // [RULE_02]

  property p_cs_check;
    @(posedge clock) disable iff (!rst_n)
      (seq_reg == SEQ_CHK_CS) |=> (seq_reg == ($past(rom_select_n) ? SEQ_IDLE : SEQ_FETCH0));
  endproperty
  a_cs_check: assert property (p_cs_check) else $error("chip-select check took the wrong branch");  // [RULE_03] [RULE_24]

  property p_go_start;
    @(posedge clock) disable iff (!rst_n || data_bus_busy_n)
      s_fetch_start |=> access_go_reg ##1 (dly_reg == DLY_S1) && latch_gate_a;
  endproperty
  a_go_start: assert property (p_go_start) else $error("first access did not start");  // [RULE_05] [RULE_07]

  property p_gate_window;
    @(posedge clock) disable iff (!rst_n || data_bus_busy_n)
      s_count_run |-> !latch_open_reg && word_done_reg && (gate == 4'h0);
  endproperty
  a_gate_window: assert property (p_gate_window) else $error("gate did not close at final delay state");  // [RULE_08] [RULE_09]

  property p_open_time;
    @(posedge clock) disable iff (!rst_n)
      $fell(latch_open_reg) && !$past(data_bus_busy_n) |-> ($past(open_cnt_reg) >= 4'(ROM_ACCESS_CYCLES));
  endproperty
  a_open_time: assert property (p_open_time) else $error("gate closed before memory access time");  // [RULE_10]

  property p_word_done;
    @(posedge clock) disable iff (!rst_n || data_bus_busy_n)
      word_done_reg |=> (dly_reg == DLY_S0) && (seq_reg != $past(seq_reg));
  endproperty
  a_word_done: assert property (p_word_done) else $error("word_done did not advance both machines");  // [RULE_11] [RULE_17]

  property p_restart;
    @(posedge clock) disable iff (!rst_n || data_bus_busy_n || rom_select_n)
      word_done_reg && (seq_reg != SEQ_FETCH3) |=> access_go_reg ##1 (dly_reg == DLY_S1);
  endproperty
  a_restart: assert property (p_restart) else $error("next counted access did not start at once");  // [RULE_12]

  property p_no_fifth;
    @(posedge clock) disable iff (!rst_n)
      (seq_reg == SEQ_FETCH3) && $past(seq_reg == SEQ_FETCH3) |-> !access_go_reg;
  endproperty
  a_no_fifth: assert property (p_no_fifth) else $error("access_go held in the last fetch state");  // [RULE_14]

  property p_pre_ack;
    @(posedge clock) disable iff (!rst_n)
      pre_early_ack |-> (dly_reg == DLY_S8) && (seq_reg == SEQ_FETCH3) && (rom_addr_lo == 2'h3) ##1 !pre_early_ack;
  endproperty
  a_pre_ack: assert property (p_pre_ack) else $error("pre_early_ack outside the last access");  // [RULE_15] [RULE_25]

  property p_decide;
    @(posedge clock) disable iff (!rst_n)
      (seq_reg == SEQ_DECIDE) |=> (seq_reg == (!$past(transfer_start_n) ? SEQ_CHK_RW :
                                              ($past(data_bus_busy_n) ? SEQ_IDLE : SEQ_CHK_CS)));
  endproperty
  a_decide: assert property (p_decide) else $error("decision state took the wrong branch");  // [RULE_19] [RULE_20] [RULE_21]

  property p_length;
    @(posedge clock) disable iff (!rst_n || data_bus_busy_n)
      s_fetch_start |=> ##43 (seq_reg == SEQ_FETCH3) && word_done_reg ##1 (seq_reg == SEQ_DECIDE);
  endproperty
  a_length: assert property (p_length) else $error("64-bit read did not take its fixed length");  // [RULE_22]

  property p_abort;
    @(posedge clock) disable iff (!rst_n)
      data_bus_busy_n && (seq_is_fetch(seq_reg) || (dly_reg != DLY_S0)) |=>
        (seq_reg == SEQ_IDLE) && (dly_reg == DLY_S0);
  endproperty
  a_abort: assert property (p_abort) else $error("machines did not return idle on busy release");  // [RULE_23]

  property p_drive;
    @(posedge clock) disable iff (!rst_n)
      cpu_data_oe == !rom_select_n;
  endproperty
  a_drive: assert property (p_drive) else $error("data bus driven without rom_select");  // [RULE_26]

endmodule
`default_nettype wire

// >>> wbnrr_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module wbnrr_far_model (
  input  wire logic        clock,
  input  wire logic [1:0]  rom_addr_lo,
  input  wire logic        pre_early_ack,
  input  wire logic [63:0] rom_words,
  output var logic  [15:0] rom_data,
  output var logic         early_ack,
  output var logic         transfer_ack
);
  import wbnrr_pkg::*;

  logic [1:0] last_addr;
  int         age;

  // ----------------------------------------------------------------
  // Start-up values
  // ----------------------------------------------------------------
  initial begin
    early_ack = 1'b0;
    transfer_ack = 1'b0;
    rom_data = 16'h0000;
    last_addr = 2'h0;
    age = 0;
  end

  // Acknowledge chain: early ack one clock after pre_early_ack, transfer ack one clock later.
  always @(posedge clock) begin
    early_ack    <= pre_early_ack;
    transfer_ack <= early_ack;
  end

  // Memory shows the inverted word until its access time has run since the address moved.
  always @(negedge clock) begin
    age = (rom_addr_lo != last_addr) ? 0 : age + 1;
    last_addr = rom_addr_lo;
    if (age * CLOCK_PERIOD_NS + CLOCK_PERIOD_NS / 2 >= ROM_ACCESS_NS) begin
      rom_data <= rom_words[63 - 16 * rom_addr_lo -: 16];
    end else begin
      rom_data <= ~rom_words[63 - 16 * rom_addr_lo -: 16];
    end
  end
endmodule
`default_nettype wire

// >>> wbnrr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wbnrr_top_tb;
  import wbnrr_pkg::*;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        transfer_start_n = 1'b1;
  logic        data_bus_busy_n = 1'b1;
  logic        read_not_write = 1'b0;
  logic        relocation_select = 1'b0;
  logic        rom_select_n = 1'b1;
  logic [15:0] rom_data;
  logic [1:0]  rom_addr_lo;
  logic        latch_gate_a, latch_gate_b, latch_gate_c, latch_gate_d;
  logic        pre_early_ack, early_ack, transfer_ack, cpu_data_oe;
  logic [63:0] cpu_data_out;
  logic [63:0] words = 64'h0;
  logic [63:0] exp_q[$];
  logic [2:0]  refuse[3] = '{3'h0, 3'h6, 3'h5};
  wire  [3:0]  gates;
  integer      seed = 32'hb0eed0c2;
  int          miscompares = 0;
  int          cmp_count = 0;

  assign gates = {latch_gate_a, latch_gate_b, latch_gate_c, latch_gate_d};

  always #20 clock = ~clock;

  wbnrr_top DUT (.clock(clock), .rst_n(rst_n), .transfer_start_n(transfer_start_n),
    .data_bus_busy_n(data_bus_busy_n), .read_not_write(read_not_write),
    .relocation_select(relocation_select), .rom_select_n(rom_select_n), .rom_data(rom_data),
    .rom_addr_lo(rom_addr_lo), .latch_gate_a(latch_gate_a), .latch_gate_b(latch_gate_b),
    .latch_gate_c(latch_gate_c), .latch_gate_d(latch_gate_d), .pre_early_ack(pre_early_ack),
    .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe));

  wbnrr_far_model u_far (.clock(clock), .rom_addr_lo(rom_addr_lo), .pre_early_ack(pre_early_ack),
    .rom_words(words), .rom_data(rom_data), .early_ack(early_ack), .transfer_ack(transfer_ack));

  // ----------------------------------------------------------------
  // Comparison and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Processor side
  // ----------------------------------------------------------------
  // Raises transfer start for one clock with the given cycle qualifiers.
  task automatic begin_xfer(input logic rnw, input logic reloc, input logic sel_n);
    transfer_start_n = 1'b0;
    data_bus_busy_n = 1'b0;
    read_not_write = rnw;
    relocation_select = reloc;
    rom_select_n = sel_n;  // Decoded from the address alone
    @(negedge clock);
    transfer_start_n = 1'b1;
  endtask

  // Checks that nothing moves for a number of clocks.
  task automatic quiet(input int k);
    repeat (k) begin
      @(negedge clock);
      check({gates, pre_early_ack}, 5'h00);
    end
  endtask

  // Runs one read of the given number of 64-bit beats; chain keeps busy for a following start.
  task automatic xfer(input int beats, input bit chain);
    int n;
    int pea_n;
    int pea_at;
    for (int b = 0; b < beats; b++) begin
      words = {$random(seed), $random(seed)};
      exp_q.push_back(words);
      if (b == 0) begin
        begin_xfer(1'b1, 1'b0, 1'b0);
      end
      n = (b == 0) ? 1 : 0;
      pea_n = 0;
      pea_at = 0;
      do begin
        @(negedge clock);
        n++;
        if (pre_early_ack === 1'b1) begin
          pea_n++;
          pea_at = n;
        end
      end while (transfer_ack !== 1'b1 && n < 200);
      check(n, TRANSFER_CYCLES - 2);
      check(pea_n, 1);
      check(n - pea_at, 2);
      check(cpu_data_out, exp_q.pop_front());
    end
    @(negedge clock);
    if (!chain) begin
      data_bus_busy_n = 1'b1;  // Transfer over, address released
      rom_select_n = 1'b1;
    end
  endtask

  // Gate and data-bus watch, sampled well after the drive edge.
  always begin
    @(negedge clock);
    #5;
    check(cpu_data_oe, !rom_select_n);
    if (gates !== 4'h0) begin
      check(gates, 4'h8 >> rom_addr_lo);
    end
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 0, 1);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    quiet(10);
    $display("test idle done");
    for (int i = 0; i < 3; i++) begin
      begin_xfer(refuse[i][2], refuse[i][1], refuse[i][0]);
      quiet(50);
      data_bus_busy_n = 1'b1;
      rom_select_n = 1'b1;
      @(negedge clock);
    end
    $display("test refusals done");
    xfer(1, 1'b0);
    quiet(20);
    $display("test single done");
    xfer(1, 1'b1);
    xfer(1, 1'b0);
    quiet(5);
    $display("test back_to_back done");
    xfer(4, 1'b0);
    quiet(5);
    $display("test burst done");
    begin_xfer(1'b1, 1'b0, 1'b0);
    repeat (13) @(negedge clock);
    data_bus_busy_n = 1'b1;
    rom_select_n = 1'b1;
    quiet(60);
    xfer(1, 1'b0);
    quiet(5);
    $display("test abort done");
    complete_run();
  end
endmodule
`default_nettype wire
